// *** rtl/dps_defines.svh ***
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
// Notes on behaviour
// - Measurement end sets bit 0, bytes 8-11.
// - Channel interrupts only with diagnostics-plus-process selection.
// - Global diagnostic interrupt switched by enable setting.
// - Repeat event while handled raises diagnostic interrupt.
// - Diagnostic interrupt preempts running process handling.
// - Other channels' events are stored during diagnostics.
// - Stored diagnostics go first, then stored processes.
// - Latched channel's further process events are dropped.
// - Process completion triggers outgoing diagnostic interrupt.
// - Events between incoming and outgoing are dropped.
// - Fault indicator lit from incoming to outgoing.
// - Each diagnostic dispatch writes one buffer entry.
// - Record set 0 placed in event word.
// - Last diagnostic record readable while interrupt disabled; only channel repeat events update it, module faults do not.
// - Byte 0 holds four cause flags.
// - Fail and internal bits follow their causes.
// - Byte 1 low nibble holds module class.
// - Byte 1 bit 4 flags channel information.
// - Byte 2 bit 4 flags missing supply.
// - Byte 3 bit 6 lost, zero outgoing.
// - Outgoing message only while enable still active.
// - Record set 0 layout common to modes.
// - Record set 1 is record 0 plus twelve bytes.

// Register byte offsets.
`define DPS_OFS_CTRL        6'h00
`define DPS_OFS_STATUS      6'h04
`define DPS_OFS_HANDLER     6'h08
`define DPS_OFS_EVDW        6'h0c
`define DPS_OFS_MODADDR     6'h10
`define DPS_OFS_REC0        6'h14
`define DPS_OFS_REC1_W1     6'h18
`define DPS_OFS_REC1_W2     6'h1c
`define DPS_OFS_REC1_W3     6'h20

// Control fields and reset values.
`define DPS_CTRL_RST        4'h0
`define DPS_CTRL_DIAG_EN    0
`define DPS_CTRL_SEL_DP     1
`define DPS_CTRL_FUNC       2
`define DPS_CTRL_REC_EV     3
`define DPS_HANDLER_END     0
`define DPS_MODADDR_RST     16'h0000

// Record set 0 fields.
`define DPS_B0_MOD_FAIL     0
`define DPS_B0_INT_ERR      1
`define DPS_B0_CH_ERR       3
`define DPS_B0_EXT_SUP      4
`define DPS_B1_CH_INFO      4
`define DPS_B2_SUPPLY       4
`define DPS_B3_LOST         6
`define DPS_CLASS_DIGITAL   4'hf
`define DPS_CLASS_FUNCTION  4'h8
`define DPS_MOD_CHAN        3'h4

// Record set 1 header bytes.
`define DPS_REC1_CH_TYPE    8'h76
`define DPS_REC1_DIAG_BITS  8'h08
`define DPS_REC1_NUM_CH     8'h04
`endif

// *** rtl/dps_pkg.sv ***
package dps_pkg;
  // Sequencer states, Gray coded along idle, process, incoming, outgoing.
  typedef enum logic [1:0] {
    DPS_IDLE     = 2'b00,
    DPS_PROC     = 2'b01,
    DPS_DIAG_IN  = 2'b11,
    DPS_DIAG_OUT = 2'b10
  } dps_state_t;

  // Four bytes of record set 0.
  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } dps_rec0_t;

  // Queued diagnostic request; channel 4 is the module-level fault.
  typedef struct packed {
    logic       outgoing;
    logic [2:0] chan;
  } dps_dreq_t;

  // Diagnostic buffer entry.
  typedef struct packed {
    logic        outgoing;
    logic [7:0]  cause;
    logic [15:0] mod_addr;
  } dps_entry_t;

  // Synchronised fault pins.
  typedef struct packed {
    logic supply_in;
    logic supply_out;
    logic short_out;
  } dps_fault_t;
endpackage

// *** rtl/dps_sync.sv ***
`timescale 1ns/10ps
module dps_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // Asynchronous input and its synchronised copy.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flip-flops; only the second one is read.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// *** rtl/dps_fifo.sv ***
`timescale 1ns/10ps
module dps_fifo #(
  parameter int W = 4,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // Filling side.
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Draining side.
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Depth must be a power of two so the pointers wrap by themselves.
  assign in_ready_o  = cnt_q != (AW+1)'(D);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write.
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** rtl/dps_top.sv ***
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "dps_defines.svh"
module dps_top
  import dps_pkg::*;
#(
  parameter int QDEPTH = 8
) (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Avalon-MM register slave.
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Measurement end pulses from same-clock channel logic.
  input  wire logic [3:0]  meas_end_i,
  // Fault pins, asynchronous.
  input  wire logic        supply_in_missing_i,
  input  wire logic        supply_out_missing_i,
  input  wire logic        out_short_i,
  // Handler requests, fault indicator and buffer entries.
  output logic             proc_irq_o,
  output logic             diag_irq_o,
  output logic             sys_fault_o,
  output logic             diag_entry_valid_o,
  output dps_entry_t       diag_entry_o
);
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [3:0]  ctrl_q;
  logic [15:0] modaddr_q;
  logic        wr_acc;
  logic        end_req;
  logic        diag_en;
  dps_state_t  state_q;
  dps_state_t  state_d;
  logic [2:0]  cur_ch_q;
  logic [2:0]  ch_d;
  logic [3:0]  proc_busy_q;
  logic [3:0]  diag_latch_q;
  logic [3:0]  lost_q;
  logic        fault_latch_q;
  logic        fault_prev_q;
  logic [3:0]  preq_q;
  logic [4:0]  dinq_q;
  logic [4:0]  doutq_q;
  logic        preempt_q;
  logic [1:0]  preempt_ch_q;
  dps_rec0_t   rec_q;
  dps_rec0_t   rec_new;
  logic [31:0] evdw_q;
  dps_entry_t  entry_q;
  logic        entry_vld_q;
  logic [7:0]  entry_cnt_q;
  logic        proc_irq_q;
  logic        diag_irq_q;
  logic        sys_fault_q;
  dps_fault_t  fault_s;
  logic        fault_any;
  logic [3:0]  ev;
  logic [3:0]  lost_ev;
  logic [3:0]  new_proc;
  logic        d_pop;
  logic        p_pop;
  logic        preempt_set;
  logic        done_proc;
  logic [3:0]  done_mask;
  logic [4:0]  out_disp;
  logic        d_in_valid;
  logic        d_in_ready;
  dps_dreq_t   d_in_data;
  logic        d_out_valid;
  dps_dreq_t   d_out_data;
  logic        p_in_ready;
  logic        p_out_valid;
  logic [1:0]  p_out_data;
  logic [2:0]  p_first;
  logic [4:0]  din_clr;
  logic [4:0]  dout_clr;
  logic [3:0]  pclr;

  // Lowest set bit of a request vector, 3'h7 when none is set.
  function automatic logic [2:0] first_set(input logic [4:0] v);
    logic [2:0] idx;
    idx = 3'h7;
    for (int i = 4; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Record set 0 from the cause of a diagnostic event.
  function automatic dps_rec0_t build_rec(input logic lost, input logic outgoing,
                                          input dps_fault_t f, input logic func);
    dps_rec0_t r;
    logic      sup;
    logic      dev;
    r   = '0;
    sup = f.supply_in | f.supply_out;
    dev = sup | f.short_out;
    r.b0[`DPS_B0_MOD_FAIL] = lost | dev;
    r.b0[`DPS_B0_INT_ERR]  = dev;
    r.b0[`DPS_B0_CH_ERR]   = lost;
    r.b0[`DPS_B0_EXT_SUP]  = sup;
    r.b1[3:0] = func ? `DPS_CLASS_FUNCTION : `DPS_CLASS_DIGITAL;
    r.b1[`DPS_B1_CH_INFO]  = lost | dev;
    r.b2[`DPS_B2_SUPPLY]   = sup;
    r.b3[`DPS_B3_LOST]     = lost & ~outgoing;
    return r;
  endfunction

  // Fault pins pass two flip-flops before use.
  dps_sync #(
    .W (3)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .d_i       ({supply_in_missing_i, supply_out_missing_i, out_short_i}),
    .q_o       (fault_s)
  );

  // Bus handshake: every access answers one cycle after it is raised.
  assign wr_acc  = avs_write_i && !wait_q;
  assign end_req = wr_acc && avs_address_i == `DPS_OFS_HANDLER &&
                   avs_byteenable_i[0] && avs_writedata_i[`DPS_HANDLER_END];
  assign diag_en = ctrl_q[`DPS_CTRL_DIAG_EN];

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    case (avs_address_i)
      `DPS_OFS_CTRL:    rd_mux = {28'h0, ctrl_q};
      `DPS_OFS_STATUS:  rd_mux = {entry_cnt_q, 6'h00, 3'h0, fault_latch_q, diag_latch_q,
                                  proc_busy_q, sys_fault_q, cur_ch_q, state_q};
      `DPS_OFS_EVDW:    rd_mux = evdw_q;
      `DPS_OFS_MODADDR: rd_mux = {16'h0, modaddr_q};
      `DPS_OFS_REC0:    rd_mux = rec_q;
      `DPS_OFS_REC1_W1: rd_mux = {4'h0, lost_q, `DPS_REC1_NUM_CH, `DPS_REC1_DIAG_BITS,
                                  `DPS_REC1_CH_TYPE};
      `DPS_OFS_REC1_W2: rd_mux = {7'h0, lost_q[3], 7'h0, lost_q[2], 7'h0, lost_q[1],
                                  7'h0, lost_q[0]};
      default:          rd_mux = 32'h0;
    endcase
  end

  // Read data is captured while waitrequest is still high.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Control and module address registers.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q    <= `DPS_CTRL_RST;
      modaddr_q <= `DPS_MODADDR_RST;
    end else if (wr_acc) begin
      if (avs_address_i == `DPS_OFS_CTRL && avs_byteenable_i[0]) begin
        ctrl_q <= avs_writedata_i[3:0];
      end
      if (avs_address_i == `DPS_OFS_MODADDR && avs_byteenable_i[0]) begin
        modaddr_q[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_address_i == `DPS_OFS_MODADDR && avs_byteenable_i[1]) begin
        modaddr_q[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // Event classification per channel.
  assign ev        = meas_end_i & {4{ctrl_q[`DPS_CTRL_SEL_DP]}};
  assign lost_ev   = ev & ~diag_latch_q & proc_busy_q;
  assign new_proc  = ev & ~diag_latch_q & ~proc_busy_q;
  assign fault_any = |fault_s;
  assign done_proc = state_q == DPS_PROC && end_req;
  assign done_mask = done_proc ? 4'(4'h1 << cur_ch_q[1:0]) : 4'h0;
  assign out_disp  = (d_pop && d_out_data.outgoing) ? 5'(5'h1 << d_out_data.chan) : 5'h0;

  // Sequencer: stored diagnostics first, then preempted, then stored processes.
  always_comb begin
    state_d     = state_q;
    ch_d        = cur_ch_q;
    d_pop       = 1'b0;
    p_pop       = 1'b0;
    preempt_set = 1'b0;
    case (state_q)
      DPS_IDLE: begin
        if (d_out_valid) begin
          d_pop   = 1'b1;
          state_d = d_out_data.outgoing ? DPS_DIAG_OUT : DPS_DIAG_IN;
          ch_d    = d_out_data.chan;
        end else if (preempt_q) begin
          state_d = DPS_PROC;
          ch_d    = {1'b0, preempt_ch_q};
        end else if (p_out_valid) begin
          p_pop   = 1'b1;
          state_d = DPS_PROC;
          ch_d    = {1'b0, p_out_data};
        end
      end
      DPS_PROC: begin
        if (end_req) begin
          state_d = DPS_IDLE;
        end else if (d_out_valid) begin
          state_d     = DPS_IDLE;
          preempt_set = 1'b1;
        end
      end
      DPS_DIAG_IN, DPS_DIAG_OUT: begin
        if (end_req) begin
          state_d = DPS_IDLE;
        end
      end
      default: begin
        state_d = DPS_IDLE;
      end
    endcase
  end

  // Sequencer state and preemption memory.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q      <= DPS_IDLE;
      cur_ch_q     <= 3'h0;
      preempt_q    <= 1'b0;
      preempt_ch_q <= 2'h0;
    end else begin
      state_q  <= state_d;
      cur_ch_q <= ch_d;
      if (preempt_set) begin
        preempt_q    <= 1'b1;
        preempt_ch_q <= cur_ch_q[1:0];
      end else if (state_q == DPS_IDLE && !d_out_valid) begin
        preempt_q <= 1'b0;
      end
    end
  end

  preempt_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == DPS_PROC && d_out_valid && !end_req |=> state_q == DPS_IDLE && preempt_q)
    else $error("Diagnostic did not preempt process handling.");
  diag_first_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == DPS_IDLE && d_out_valid |=> state_q inside {DPS_DIAG_IN, DPS_DIAG_OUT})
    else $error("Stored process went before stored diagnostic.");

  // Channel bookkeeping; a set in the same cycle wins over a clear.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proc_busy_q   <= 4'h0;
      diag_latch_q  <= 4'h0;
      lost_q        <= 4'h0;
      fault_latch_q <= 1'b0;
      fault_prev_q  <= 1'b0;
    end else begin
      proc_busy_q  <= (proc_busy_q & ~done_mask) | new_proc;
      diag_latch_q <= (diag_latch_q & ~(out_disp[3:0] | (done_mask & {4{!diag_en}})))
                      | (lost_ev & {4{diag_en}});
      lost_q       <= (lost_q & ~(out_disp[3:0] | (done_mask & {4{!diag_en}}))) | lost_ev;
      fault_latch_q <= (fault_latch_q & ~out_disp[4] & ~(!fault_any & !diag_en))
                       | (fault_any & !fault_prev_q & diag_en);
      fault_prev_q <= fault_any;
    end
  end

  no_new_in_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    |diag_latch_q |=> (dinq_q[3:0] & ~$past(dinq_q[3:0]) & $past(diag_latch_q)) == 4'h0)
    else $error("Event between incoming and outgoing was kept.");
  gate_sel_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(proc_busy_q[0]) |-> $past(ctrl_q[`DPS_CTRL_SEL_DP]))
    else $error("Channel event taken without interrupt selection.");

  // Pending pushes toward the stores, one per cycle, incoming before outgoing, lowest channel first.
  assign d_in_valid         = (|dinq_q) || (|doutq_q);
  assign d_in_data.outgoing = ~|dinq_q;
  assign d_in_data.chan     = (|dinq_q) ? first_set(dinq_q) : first_set(doutq_q);
  assign din_clr  = (d_in_ready && |dinq_q) ? 5'(5'h1 << d_in_data.chan) : 5'h0;
  assign dout_clr = (d_in_ready && d_in_valid && !(|dinq_q)) ?
                    5'(5'h1 << d_in_data.chan) : 5'h0;
  assign p_first  = first_set({1'b0, preq_q});
  assign pclr     = (p_in_ready && |preq_q) ? 4'(4'h1 << p_first[1:0]) : 4'h0;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dinq_q  <= 5'h0;
      doutq_q <= 5'h0;
      preq_q  <= 4'h0;
    end else begin
      dinq_q  <= (dinq_q & ~din_clr) | {fault_any & !fault_prev_q & diag_en,
                                        lost_ev & {4{diag_en}}};
      doutq_q <= (doutq_q & ~dout_clr) | {!fault_any & fault_prev_q & fault_latch_q & diag_en,
                                          done_mask & diag_latch_q & {4{diag_en}}};
      preq_q  <= (preq_q & ~pclr) | new_proc;
    end
  end

  outgoing_req_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    done_proc && |(done_mask & diag_latch_q) && diag_en |=> |doutq_q[3:0])
    else $error("Finished process did not request outgoing diagnostic.");

  // Intermediate stores, released in arrival order.
  dps_fifo #(
    .W (4),
    .D (QDEPTH)
  ) u_diag_store (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (d_in_valid),
    .in_data_i   (d_in_data),
    .in_ready_o  (d_in_ready),
    .out_valid_o (d_out_valid),
    .out_data_o  (d_out_data),
    .out_ready_i (d_pop)
  );

  dps_fifo #(
    .W (2),
    .D (QDEPTH)
  ) u_proc_store (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (|preq_q),
    .in_data_i   (p_first[1:0]),
    .in_ready_o  (p_in_ready),
    .out_valid_o (p_out_valid),
    .out_data_o  (p_out_data),
    .out_ready_i (p_pop)
  );

  // Record and event word on each dispatch.
  assign rec_new = build_rec(d_out_data.chan != `DPS_MOD_CHAN, d_out_data.outgoing,
                             fault_s, ctrl_q[`DPS_CTRL_FUNC]);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rec_q  <= '0;
      evdw_q <= 32'h0;
    end else if (d_pop) begin
      rec_q  <= rec_new;
      evdw_q <= ctrl_q[`DPS_CTRL_REC_EV] ? rec_new : 32'h0;
    end else if (state_q != DPS_PROC && state_d == DPS_PROC) begin
      evdw_q <= 32'(32'h1 << {ch_d[1:0], 3'b000});
    end else if (|lost_ev && !diag_en) begin
      rec_q <= build_rec(1'b1, 1'b0, fault_s, ctrl_q[`DPS_CTRL_FUNC]);
    end
  end

  rec_event_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == DPS_DIAG_IN && ctrl_q[`DPS_CTRL_REC_EV] && $stable(ctrl_q) |-> evdw_q == rec_q)
    else $error("Record set 0 missing from event word.");

  // Diagnostic buffer entries.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      entry_q     <= '0;
      entry_vld_q <= 1'b0;
      entry_cnt_q <= 8'h00;
    end else begin
      entry_vld_q <= d_pop;
      if (d_pop) begin
        entry_q     <= {d_out_data.outgoing, rec_new.b0, modaddr_q};
        entry_cnt_q <= entry_cnt_q + 8'h01;
      end
    end
  end

  entry_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    state_q == DPS_IDLE && d_out_valid |=> diag_entry_valid_o ##1 !diag_entry_valid_o)
    else $error("Diagnostic dispatch without one buffer entry.");
  out_byte3_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    diag_entry_valid_o && diag_entry_o.outgoing |-> rec_q.b3 == 8'h00)
    else $error("Outgoing record byte 3 not zero.");
  class_code_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    diag_entry_valid_o |-> rec_q.b1[3:0] ==
      ($past(ctrl_q[`DPS_CTRL_FUNC]) ? 4'h8 : 4'hf))
    else $error("Module class code wrong.");

  // Handler requests and fault indicator.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      proc_irq_q  <= 1'b0;
      diag_irq_q  <= 1'b0;
      sys_fault_q <= 1'b0;
    end else begin
      proc_irq_q  <= state_d == DPS_PROC;
      diag_irq_q  <= state_d == DPS_DIAG_IN || state_d == DPS_DIAG_OUT;
      sys_fault_q <= (|diag_latch_q) || fault_latch_q;
    end
  end

  fault_led_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(|diag_latch_q) |-> ##1 sys_fault_o [*2])
    else $error("Fault indicator not lit after incoming diagnostic.");

  assign avs_waitrequest_o  = wait_q;
  assign avs_readdata_o     = rdata_q;
  assign proc_irq_o         = proc_irq_q;
  assign diag_irq_o         = diag_irq_q;
  assign sys_fault_o        = sys_fault_q;
  assign diag_entry_valid_o = entry_vld_q;
  assign diag_entry_o       = entry_q;
endmodule

// *** verif/dps_buf_model.sv ***
`timescale 1ns/10ps
module dps_buf_model
  import dps_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // Entries offered by the block.
  input  wire logic       valid_i,
  input  wire dps_entry_t entry_i,
  // Stored count and newest entry.
  output logic [7:0]      cnt_o,
  output dps_entry_t      last_o
);
  // Each valid pulse stores one buffer entry, as the host buffer would.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_o  <= 8'h00;
      last_o <= '0;
    end else if (valid_i) begin
      cnt_o  <= cnt_o + 8'h01;
      last_o <= entry_i;
    end
  end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import dps_pkg::*;
  typedef struct {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} dps_row_t;
  logic clk_sys_i, nrst_i, rd, wr, sin, wrq;
  logic [5:0] adr;
  logic [31:0] wd, rdata, q;
  logic [3:0] me;
  logic pirq, dirq, sf, ev;
  dps_entry_t ent, last;
  logic [7:0] cnt;
  int bad_count, comparisons;
  dps_row_t rows [8];
  // Block under test; byte lanes and two fault pins are tied.
  dps_top u_dps_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wrq), .meas_end_i(me),
    .supply_in_missing_i(sin), .supply_out_missing_i(1'b0), .out_short_i(1'b0),
    .proc_irq_o(pirq), .diag_irq_o(dirq), .sys_fault_o(sf),
    .diag_entry_valid_o(ev), .diag_entry_o(ent));
  // Host buffer model.
  dps_buf_model u_dps_buf_model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .valid_i(ev),
    .entry_i(ent), .cnt_o(cnt), .last_o(last));
  // Clock at 20 ns period.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd  <= d;
    rd  <= !w;
    wr  <= w;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wrq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) begin
      bad_count++;
      summarize();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Waits for one of fault, diag or process request to reach a level.
  // One more edge follows so that registered results downstream have settled.
  task automatic wt(input int i, input logic v);
    int n;
    n = 0;
    while ((i == 0 ? pirq : (i == 1 ? dirq : sf)) !== v && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      summarize();
    end
    @(posedge clk_sys_i);
  endtask
  task automatic pulse(input int c);
    me <= 4'h1 << c;
    @(posedge clk_sys_i);
    me <= 4'h0;
    @(posedge clk_sys_i);
  endtask
  initial begin
    {nrst_i, rd, wr, sin, adr, wd, me} = '0;
    bad_count = 0;
    comparisons = 0;
    rows = '{'{0, 6'h00, 0, 0}, '{1, 6'h10, 32'h1234, 0}, '{0, 6'h10, 0, 32'h1234},
      '{0, 6'h3c, 0, 0}, '{0, 6'h08, 0, 0}, '{0, 6'h18, 0, 32'h00040876},
      '{0, 6'h20, 0, 0}, '{1, 6'h00, 32'hb, 0}};
    repeat (2) @(posedge clk_sys_i);
    chk("irq in reset", {sf, dirq, pirq, ev}, 0);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    // Register table rows.
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("reg", q, rows[i].e);
    end
    // End-of-measurement bit per channel.
    for (int c = 0; c < 4; c++) begin
      pulse(c);
      wt(0, 1'b1);
      bus(0, 6'h0c, 0);
      chk("evdw", q, 32'h1 << (8 * c));
      bus(1, 6'h08, 1);
      wt(0, 1'b0);
    end
    // Repeat on busy channel escalates; channel 0 is stored meanwhile.
    pulse(2);
    wt(0, 1'b1);
    pulse(2);
    wt(1, 1'b1);
    chk("preempt", pirq, 0);
    chk("fault", sf, 1);
    chk("entry", {cnt[6:0], last}, {7'h1, 1'b0, 8'h09, 16'h1234});
    bus(0, 6'h0c, 0);
    chk("record", q, 32'h40001f09);
    pulse(0);
    pulse(2);
    bus(1, 6'h08, 1);
    wt(0, 1'b1);
    bus(0, 6'h04, 0);
    chk("order", q[4:2], 3'h2);
    bus(1, 6'h08, 1);
    wt(1, 1'b1);
    chk("outgoing", {cnt, last.outgoing}, {8'h2, 1'b1});
    bus(0, 6'h14, 0);
    chk("rec out", q, 32'h00001f09);
    bus(1, 6'h08, 1);
    wt(2, 1'b0);
    wt(0, 1'b1);
    bus(0, 6'h0c, 0);
    chk("stored", q, 32'h1);
    bus(1, 6'h08, 1);
    // Missing input supply raises a module-level diagnostic.
    sin <= 1'b1;
    wt(1, 1'b1);
    bus(0, 6'h14, 0);
    chk("supply", q, 32'h00101f13);
    bus(1, 6'h08, 1);
    sin <= 1'b0;
    wt(1, 1'b1);
    chk("supply out", {cnt, last.outgoing}, {8'h4, 1'b1});
    bus(1, 6'h08, 1);
    // Select cleared: events are ignored.
    bus(1, 6'h00, 32'h0);
    pulse(1);
    repeat (6) @(posedge clk_sys_i);
    chk("no select", pirq, 0);
    summarize();
  end
endmodule
